// file: verilog/addr_ctl_regs.vh
// Purpose: offsets, field positions, reset values for addressing block
// Assumes: register index is the printed special-register address
// Notes: byte address on the APB is four times the index
`ifndef ADDR_CTL_REGS_VH
`define ADDR_CTL_REGS_VH

`define IDX_STACK_POINTER 8'h81
`define IDX_DPTR0_LO 8'h82
`define IDX_DPTR0_HI 8'h83
`define IDX_SECONDARY_DATA_POINTER_LO 8'h84
`define IDX_SECONDARY_DATA_POINTER_HI 8'h85
`define IDX_DATA_POINTER_CHOICE 8'h86
`define IDX_FLASH_WAIT_STATES 8'h92
`define IDX_PRIMARY_POINTER_TOP 8'h93
`define IDX_SECONDARY_POINTER_TOP 8'h95
`define IDX_STACK_HIGH_BYTE 8'h9B
`define IDX_ADDRESS_MODE_CONTROL 8'h9D
`define IDX_CPU_INTERRUPT_STATUS 8'hC5
`define IDX_EXTERNAL_DATA_RAM_BASE_RELOC 8'hC6
`define IDX_MOVX_RI_HIGH_BYTE 8'hDA
`define IDX_MOVX_RI_TOP_BYTE 8'hFA
`define IDX_TIMED_ACCESS_KEY 8'hF0

`define RST_ZERO 8'h00
`define RST_FLASH_WAIT_STATES 4'h7

`define TA_KEY1 8'hAA
`define TA_KEY2 8'h55
`define TA_WINDOW 3'h4

`define BIT_HIGH_PRIO 6
`define BIT_LOW_PRIO 5
`define BIT_POINTER_CHOICE 0
`define BIT_AUTO_TOGGLE 5
`define BIT_STEP_DIR0 6
`define BIT_STEP_DIR1 7
`define BIT_VECTOR_RELOCATE 5
`define BIT_MOVX_RI_HIGH_EN 3
`define BIT_STACK_MODE 2
`define BIT_ADDR_MODE_HI 1

`define VECTOR_RELOC_BASE 20'h0B000
`define INTERNAL_DATA_RAM_DEPTH 256

`endif

// file: verilog/stack_ram.v
// Purpose: 256-byte internal data memory holding the standard stack
// Assumes: one write or one read per cycle
// Notes: read data come out of a register, one cycle after the request
`timescale 1ns/1ns
module stack_ram (
    // clock
    input wire pclk,
    // access
    input wire wr_en,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    output reg [7:0] rdata
);
    reg [7:0] mem [0:255];

    always @(posedge pclk) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// file: verilog/addr_ctl.v
// Purpose: stack, wait-state, address mode and data pointer control
// Assumes: APB slave, no wait state on any transfer
// Notes: core events arrive as one-cycle pulses on the core port
//
// How it works
// - push writes work value at pointer+1
// - pop loads work value from pointer address
// - flat mode stack address is high:low byte
// - status bit6 high, bit5 low in service
// - serial activity status bits read zero
// - wait field n gives n+1 cycles
// - wait register resets to seven
// - external_data_ram base held in 2KB steps
// - guarded registers written only after unlock
// - large 16-bit, flat 20-bit program address
// - mode bits 00 large, 1x flat
// - relocate bit maps vectors to B000
// - stack flag reads extended stack mode
// - ri high byte from port2 or register
// - ri top byte only for ri moves
// - primary_data_pointer moves use selected pointer and top
// - choice bit0 selects pointer, reads back
// - step bits make INC PRIMARY_DATA_POINTER decrement
// - toggle flips selection after pointer use
`timescale 1ns/1ns
`include "addr_ctl_regs.vh"
module addr_ctl (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // core events
    input wire push_req,
    input wire pop_req,
    input wire [7:0] work_value,
    output reg [7:0] pop_data,
    output reg pop_valid,
    input wire primary_data_pointer_inc,
    input wire primary_data_pointer_use,
    input wire hp_active,
    input wire lp_active,
    // address forming
    input wire [7:0] port2_latch,
    input wire [7:0] ri_value,
    output reg [23:0] movx_primary_data_pointer_addr,
    output reg [23:0] movx_ri_addr,
    output reg [15:0] stack_addr,
    output reg [19:0] vector_base,
    output reg flat_mode,
    output reg [4:0] flash_access_cycles
);
    // apb state, one-hot
    localparam ST_IDLE = 2'b01;
    localparam ST_ACK = 2'b10;

    reg [1:0] st_reg;
    reg [31:0] rdata_reg;
    reg err_reg;
    reg [7:0] stack_pointer_reg;
    reg [7:0] stack_high_byte_reg;
    reg [15:0] dptr0_reg;
    reg [15:0] secondary_data_pointer_reg;
    reg [7:0] primary_pointer_top_reg;
    reg [7:0] secondary_pointer_top_reg;
    reg [7:0] data_pointer_choice_reg;
    reg [3:0] wait_state_field_reg;
    reg [7:0] addr_mode_reg;
    reg [7:0] external_data_ram_base_reloc_reg;
    reg [7:0] movx_ri_high_byte_reg;
    reg [7:0] movx_ri_top_byte_reg;
    reg [1:0] ta_state_reg;
    reg [2:0] ta_count_reg;
    reg pop_pending_reg;

    wire [7:0] idx = paddr[9:2];
    wire access = psel && penable && (st_reg == ST_ACK);
    wire wr = access && pwrite;
    wire ta_open = (ta_state_reg == 2'b10);
    wire pointer_choice = data_pointer_choice_reg[`BIT_POINTER_CHOICE];
    wire stack_ext = addr_mode_reg[`BIT_ADDR_MODE_HI];

    // decode of one mapped index, reused for every register
    function hit;
        input [7:0] a;
        input [7:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = hit(a, `IDX_STACK_POINTER) ||
                hit(a, `IDX_DPTR0_LO) || hit(a, `IDX_DPTR0_HI) ||
                hit(a, `IDX_SECONDARY_DATA_POINTER_LO) || hit(a, `IDX_SECONDARY_DATA_POINTER_HI) ||
                hit(a, `IDX_DATA_POINTER_CHOICE) ||
                hit(a, `IDX_FLASH_WAIT_STATES) ||
                hit(a, `IDX_PRIMARY_POINTER_TOP) ||
                hit(a, `IDX_SECONDARY_POINTER_TOP) ||
                hit(a, `IDX_STACK_HIGH_BYTE) ||
                hit(a, `IDX_ADDRESS_MODE_CONTROL) ||
                hit(a, `IDX_CPU_INTERRUPT_STATUS) ||
                hit(a, `IDX_EXTERNAL_DATA_RAM_BASE_RELOC) ||
                hit(a, `IDX_MOVX_RI_HIGH_BYTE) ||
                hit(a, `IDX_MOVX_RI_TOP_BYTE) ||
                hit(a, `IDX_TIMED_ACCESS_KEY);
        end
    endfunction

    // one step of a pointer, up or down
    function [15:0] step;
        input [15:0] v;
        input down;
        begin
            step = down ? v - 16'h0001 : v + 16'h0001;
        end
    endfunction

    // stack memory port
    reg ram_we;
    reg [7:0] ram_addr;
    wire [7:0] ram_rdata;

    always @* begin
        ram_we = 1'b0;
        ram_addr = stack_pointer_reg;
        if (push_req) begin
            ram_we = 1'b1;
            ram_addr = stack_pointer_reg + 8'h01;
        end else if (pop_req) begin
            ram_addr = stack_pointer_reg;
        end
    end

    stack_ram u_ram (
        .pclk(pclk),
        .wr_en(ram_we),
        .addr(ram_addr),
        .wdata(work_value),
        .rdata(ram_rdata)
    );

    // extended stack shares the internal memory: every push is stored
    // here at the low byte in either mode, the wide address goes out

    assign pready = (st_reg == ST_ACK);
    assign prdata = rdata_reg;
    assign pslverr = (st_reg == ST_ACK) && err_reg;

    // read mux
    reg [7:0] rd_byte;
    always @* begin
        rd_byte = 8'h00;
        case (idx)
            `IDX_STACK_POINTER: rd_byte = stack_pointer_reg;
            `IDX_DPTR0_LO: rd_byte = dptr0_reg[7:0];
            `IDX_DPTR0_HI: rd_byte = dptr0_reg[15:8];
            `IDX_SECONDARY_DATA_POINTER_LO: rd_byte = secondary_data_pointer_reg[7:0];
            `IDX_SECONDARY_DATA_POINTER_HI: rd_byte = secondary_data_pointer_reg[15:8];
            `IDX_DATA_POINTER_CHOICE:
                rd_byte = data_pointer_choice_reg & 8'hE1;
            `IDX_FLASH_WAIT_STATES:
                rd_byte = {4'h0, wait_state_field_reg};
            `IDX_PRIMARY_POINTER_TOP: rd_byte = primary_pointer_top_reg;
            `IDX_SECONDARY_POINTER_TOP:
                rd_byte = secondary_pointer_top_reg;
            `IDX_STACK_HIGH_BYTE: rd_byte = stack_high_byte_reg;
            `IDX_ADDRESS_MODE_CONTROL:
                rd_byte = {addr_mode_reg[7:3], stack_ext,
                    addr_mode_reg[1:0]} & 8'h2F;
            `IDX_CPU_INTERRUPT_STATUS:
                rd_byte = {1'b0, hp_active, lp_active, 5'h00};
            `IDX_EXTERNAL_DATA_RAM_BASE_RELOC: rd_byte = external_data_ram_base_reloc_reg;
            `IDX_MOVX_RI_HIGH_BYTE: rd_byte = movx_ri_high_byte_reg;
            `IDX_MOVX_RI_TOP_BYTE: rd_byte = movx_ri_top_byte_reg;
            default: rd_byte = 8'h00;
        endcase
    end

    // apb handshake: setup takes the cycle, access answers one later
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= ST_IDLE;
            rdata_reg <= 32'h00000000;
            err_reg <= 1'b0;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    if (psel && !penable) begin
                        st_reg <= ST_ACK;
                        rdata_reg <= {24'h000000, rd_byte};
                        err_reg <= !mapped(idx) || (paddr[1:0] != 2'b00)
                            || (paddr[11:10] != 2'b00);
                    end
                end
                ST_ACK: begin
                    st_reg <= ST_IDLE;
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    wire wr_ok = wr && !err_reg;

    // timed access: two key writes open a short window
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ta_state_reg <= 2'b00;
            ta_count_reg <= 3'h0;
        end else if (wr_ok && hit(idx, `IDX_TIMED_ACCESS_KEY)) begin
            if (pwdata[7:0] == `TA_KEY1) begin
                ta_state_reg <= 2'b01;
            end else if (pwdata[7:0] == `TA_KEY2 && ta_state_reg == 2'b01)
            begin
                ta_state_reg <= 2'b10;
                ta_count_reg <= `TA_WINDOW;
            end else begin
                ta_state_reg <= 2'b00;
            end
        end else if (ta_open) begin
            // window closes on any write without error or when count runs out
            if (wr_ok || ta_count_reg == 3'h0) begin
                ta_state_reg <= 2'b00;
            end else begin
                ta_count_reg <= ta_count_reg - 3'h1;
            end
        end
    end

    // register writes and core-driven updates
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_pointer_reg <= `RST_ZERO;
            stack_high_byte_reg <= `RST_ZERO;
            dptr0_reg <= 16'h0000;
            secondary_data_pointer_reg <= 16'h0000;
            primary_pointer_top_reg <= `RST_ZERO;
            secondary_pointer_top_reg <= `RST_ZERO;
            data_pointer_choice_reg <= `RST_ZERO;
            wait_state_field_reg <= `RST_FLASH_WAIT_STATES;
            addr_mode_reg <= `RST_ZERO;
            external_data_ram_base_reloc_reg <= `RST_ZERO;
            movx_ri_high_byte_reg <= `RST_ZERO;
            movx_ri_top_byte_reg <= `RST_ZERO;
        end else begin
            if (push_req) begin
                stack_pointer_reg <= stack_pointer_reg + 8'h01;
            end else if (pop_req) begin
                stack_pointer_reg <= stack_pointer_reg - 8'h01;
            end
            if (primary_data_pointer_inc) begin
                if (!pointer_choice) begin
                    dptr0_reg <= step(dptr0_reg,
                        data_pointer_choice_reg[`BIT_STEP_DIR0]);
                end else begin
                    secondary_data_pointer_reg <= step(secondary_data_pointer_reg,
                        data_pointer_choice_reg[`BIT_STEP_DIR1]);
                end
            end
            if ((primary_data_pointer_use || primary_data_pointer_inc) &&
                data_pointer_choice_reg[`BIT_AUTO_TOGGLE]) begin
                data_pointer_choice_reg[`BIT_POINTER_CHOICE] <=
                    !pointer_choice;
            end
            if (wr_ok) begin
                case (idx)
                    `IDX_STACK_POINTER: stack_pointer_reg <= pwdata[7:0];
                    `IDX_DPTR0_LO: dptr0_reg[7:0] <= pwdata[7:0];
                    `IDX_DPTR0_HI: dptr0_reg[15:8] <= pwdata[7:0];
                    `IDX_SECONDARY_DATA_POINTER_LO: secondary_data_pointer_reg[7:0] <= pwdata[7:0];
                    `IDX_SECONDARY_DATA_POINTER_HI: secondary_data_pointer_reg[15:8] <= pwdata[7:0];
                    `IDX_DATA_POINTER_CHOICE:
                        data_pointer_choice_reg <= pwdata[7:0] & 8'hE1;
                    `IDX_FLASH_WAIT_STATES:
                        wait_state_field_reg <= pwdata[3:0];
                    `IDX_PRIMARY_POINTER_TOP:
                        primary_pointer_top_reg <= pwdata[7:0];
                    `IDX_SECONDARY_POINTER_TOP:
                        secondary_pointer_top_reg <= pwdata[7:0];
                    `IDX_STACK_HIGH_BYTE:
                        stack_high_byte_reg <= pwdata[7:0];
                    `IDX_ADDRESS_MODE_CONTROL: begin
                        if (ta_open) begin
                            // stack flag is read-only, kept out
                            addr_mode_reg <= pwdata[7:0] & 8'h2B;
                        end
                    end
                    `IDX_EXTERNAL_DATA_RAM_BASE_RELOC: begin
                        if (ta_open) begin
                            external_data_ram_base_reloc_reg <= pwdata[7:0];
                        end
                    end
                    `IDX_MOVX_RI_HIGH_BYTE:
                        movx_ri_high_byte_reg <= pwdata[7:0];
                    `IDX_MOVX_RI_TOP_BYTE:
                        movx_ri_top_byte_reg <= pwdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // pop result, two cycles after the request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pop_pending_reg <= 1'b0;
            pop_data <= 8'h00;
            pop_valid <= 1'b0;
        end else begin
            pop_pending_reg <= pop_req && !push_req;
            pop_valid <= pop_pending_reg;
            if (pop_pending_reg) begin
                pop_data <= ram_rdata;
            end
        end
    end

    // address forming outputs, registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            movx_primary_data_pointer_addr <= 24'h000000;
            movx_ri_addr <= 24'h000000;
            stack_addr <= 16'h0000;
            vector_base <= 20'h00000;
            flat_mode <= 1'b0;
            flash_access_cycles <= 5'h08;
        end else begin
            movx_primary_data_pointer_addr <= pointer_choice ?
                {secondary_pointer_top_reg, secondary_data_pointer_reg} :
                {primary_pointer_top_reg, dptr0_reg};
            movx_ri_addr <= {movx_ri_top_byte_reg,
                addr_mode_reg[`BIT_MOVX_RI_HIGH_EN] ?
                movx_ri_high_byte_reg : port2_latch, ri_value};
            stack_addr <= stack_ext ?
                {stack_high_byte_reg, stack_pointer_reg} :
                {8'h00, stack_pointer_reg};
            vector_base <= addr_mode_reg[`BIT_VECTOR_RELOCATE] ?
                `VECTOR_RELOC_BASE : 20'h00000;
            flat_mode <= addr_mode_reg[`BIT_ADDR_MODE_HI];
            flash_access_cycles <= {1'b0, wait_state_field_reg} + 5'h01;
        end
    end
endmodule

// file: dv/addr_ctl_assertions.sv
// Purpose: port-level timing checks for addr_ctl
// Assumes: one clock pclk, presetn async active low
// Notes: bound from the testbench top file
`timescale 1ns/1ns
module addr_ctl_assertions (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // core events
    input wire push_req,
    input wire pop_req,
    input wire [7:0] work_value,
    input wire [7:0] pop_data,
    input wire pop_valid,
    input wire primary_data_pointer_inc,
    input wire primary_data_pointer_use,
    input wire hp_active,
    input wire lp_active,
    // address forming
    input wire [7:0] port2_latch,
    input wire [7:0] ri_value,
    input wire [23:0] movx_primary_data_pointer_addr,
    input wire [23:0] movx_ri_addr,
    input wire [15:0] stack_addr,
    input wire [19:0] vector_base,
    input wire flat_mode,
    input wire [4:0] flash_access_cycles
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire quiet = !primary_data_pointer_inc && !primary_data_pointer_use && !(psel && pwrite);
    property p_ready_after_setup;
        psel && !penable |=> pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("pready missing after setup");
    property p_ready_single;
        pready |=> !pready;
    endproperty
    a_ready_single: assert property (p_ready_single)
        else $error("pready held too long");
    property p_slverr_with_ready;
        pslverr |-> pready && psel && penable;
    endproperty
    a_slverr_with_ready: assert property (p_slverr_with_ready)
        else $error("pslverr outside access");
    property p_pop_answer;
        pop_req && !push_req |-> ##2 pop_valid;
    endproperty
    a_pop_answer: assert property (p_pop_answer)
        else $error("pop not answered in two cycles");
    property p_pop_cause;
        pop_valid |-> $past(pop_req, 2) && !$past(push_req, 2);
    endproperty
    a_pop_cause: assert property (p_pop_cause)
        else $error("pop_valid without pop");
    property p_wait_range;
        flash_access_cycles >= 5'h01 && flash_access_cycles <= 5'h10;
    endproperty
    a_wait_range: assert property (p_wait_range)
        else $error("access cycles out of range");
    property p_vector;
        vector_base == 20'h00000 || vector_base == 20'h0B000;
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector base illegal");
    property p_ri_low;
        movx_ri_addr[7:0] == $past(ri_value);
    endproperty
    a_ri_low: assert property (p_ri_low)
        else $error("ri low byte wrong");
    property p_std_stack;
        !flat_mode |-> stack_addr[15:8] == 8'h00;
    endproperty
    a_std_stack: assert property (p_std_stack)
        else $error("standard stack above 256 bytes");
    property p_primary_data_pointer_hold;
        quiet ##1 quiet |=> $stable(movx_primary_data_pointer_addr);
    endproperty
    a_primary_data_pointer_hold: assert property (p_primary_data_pointer_hold)
        else $error("pointer address moved unprompted");
endmodule

// file: dv/core_side.sv
// Purpose: core-side event source facing addr_ctl
// Assumes: events are one-cycle pulses, one per call
// Notes: work_value is scrambled when not qualified by a push
`timescale 1ns/1ns
module core_side (
    // clock
    input wire pclk,
    // events
    output reg push_req = 1'b0,
    output reg pop_req = 1'b0,
    output reg primary_data_pointer_inc = 1'b0,
    output reg primary_data_pointer_use = 1'b0,
    output reg [7:0] work_value = 8'h00
);
    // k: 1 push, 2 pop, 3 pointer step, 4 pointer use
    task ev(input [2:0] k, input [7:0] v);
        begin
            @(posedge pclk);
            work_value <= v;
            push_req <= (k == 3'h1);
            pop_req <= (k == 3'h2);
            primary_data_pointer_inc <= (k == 3'h3);
            primary_data_pointer_use <= (k == 3'h4);
            @(posedge pclk);
            work_value <= ~v;
            {push_req, pop_req, primary_data_pointer_inc, primary_data_pointer_use} <= 4'h0;
        end
    endtask
endmodule

// file: dv/test_cpu_addressing_and_pointer_control.sv
// Purpose: register and address forming tests for addr_ctl
// Assumes: apb byte address is four times the register index
// Notes: port outputs checked a few edges after their cause
`timescale 1ns/1ns
module test_cpu_addressing_and_pointer_control;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg hp_active = 1'b0;
    reg lp_active = 1'b0;
    reg [7:0] port2_latch = 8'h00;
    reg [7:0] ri_value = 8'h00;
    wire [31:0] prdata;
    wire pready, pslverr, push_req, pop_req, pop_valid, primary_data_pointer_inc, primary_data_pointer_use;
    wire [7:0] work_value, pop_data;
    wire [23:0] movx_primary_data_pointer_addr, movx_ri_addr;
    wire [15:0] stack_addr;
    wire [19:0] vector_base;
    wire flat_mode;
    wire [4:0] flash_access_cycles;
    reg [31:0] rd;
    reg err;
    integer fail_count = 0;
    integer total_checks = 0;
    integer i;
    localparam [71:0] IDX = 72'h81_86_92_9B_9D_C5_C6_DA_FA;
    always #4 pclk = ~pclk;
    addr_ctl DUT (.*);
    core_side CORE (.pclk, .push_req, .pop_req, .primary_data_pointer_inc, .primary_data_pointer_use,
        .work_value);
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", total_checks, fail_count);
            if (fail_count == 0 && total_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("mismatch %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task apb(input [7:0] idx, input w, input [31:0] d);
        integer n;
        begin
            n = 0;
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= {2'b00, idx, 2'b00};
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            // look mid-cycle: pready falls in the step of its own edge
            @(negedge pclk);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(negedge pclk);
            end
            if (n == 20) begin
                fail_count = fail_count + 1;
                wrap_up;
            end
            rd = prdata;
            err = pslverr;
            @(posedge pclk);
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rdchk(input [7:0] idx, input [31:0] e);
        begin
            apb(idx, 1'b0, 32'h0);
            chk("register", e, rd);
        end
    endtask
    task settle;
        repeat (3) @(posedge pclk);
    endtask
    task pop_chk(input [7:0] e);
        integer n;
        begin
            n = 0;
            CORE.ev(3'h2, 8'h00);
            // pop_valid stands one cycle only, so look mid-cycle
            @(negedge pclk);
            while (pop_valid !== 1'b1 && n < 5) begin
                n = n + 1;
                @(negedge pclk);
            end
            if (n == 5) begin
                fail_count = fail_count + 1;
                wrap_up;
            end
            chk("pop", {24'h0, e}, {24'h0, pop_data});
        end
    endtask
    task unlock;
        begin
            apb(8'hF0, 1'b1, 32'hAA);
            apb(8'hF0, 1'b1, 32'h55);
        end
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk("cycles", 8, flash_access_cycles);
        for (i = 0; i < 9; i = i + 1)
            rdchk(IDX[71-8*i -: 8], (IDX[71-8*i -: 8] == 8'h92) ? 7 : 0);
        apb(8'h80, 1'b0, 32'h0);
        chk("slverr", 1, err);
        apb(8'h92, 1'b1, 32'hFF);
        rdchk(8'h92, 32'h0F);
        chk("slverr", 0, err);
        settle;
        chk("cycles", 16, flash_access_cycles);
        apb(8'h92, 1'b1, 32'h00);
        settle;
        chk("cycles", 1, flash_access_cycles);
        hp_active <= 1'b1;
        rdchk(8'hC5, 32'h40);
        lp_active <= 1'b1;
        apb(8'hC5, 1'b1, 32'hFF);
        rdchk(8'hC5, 32'h60);
        hp_active <= 1'b0;
        lp_active <= 1'b0;
        rdchk(8'hC5, 32'h00);
        // stack pushes and pops nest
        apb(8'h81, 1'b1, 32'h10);
        CORE.ev(3'h1, 8'hA5);
        CORE.ev(3'h1, 8'h3C);
        rdchk(8'h81, 32'h12);
        pop_chk(8'h3C);
        pop_chk(8'hA5);
        rdchk(8'h81, 32'h10);
        port2_latch <= 8'h77;
        ri_value <= 8'h34;
        apb(8'hDA, 1'b1, 32'h9A);
        apb(8'hFA, 1'b1, 32'h5C);
        settle;
        chk("ri", 24'h5C7734, movx_ri_addr);
        apb(8'h82, 1'b1, 32'h34);
        apb(8'h83, 1'b1, 32'h12);
        apb(8'h93, 1'b1, 32'h01);
        apb(8'h84, 1'b1, 32'hEF);
        apb(8'h85, 1'b1, 32'hBE);
        apb(8'h95, 1'b1, 32'h02);
        settle;
        chk("primary_data_pointer", 24'h011234, movx_primary_data_pointer_addr);
        apb(8'h86, 1'b1, 32'hC1);
        CORE.ev(3'h3, 8'h00);
        settle;
        chk("primary_data_pointer", 24'h02BEEE, movx_primary_data_pointer_addr);
        apb(8'h86, 1'b1, 32'h41);
        CORE.ev(3'h3, 8'h00);
        settle;
        chk("primary_data_pointer", 24'h02BEEF, movx_primary_data_pointer_addr);
        apb(8'h86, 1'b1, 32'h40);
        CORE.ev(3'h3, 8'h00);
        settle;
        chk("primary_data_pointer", 24'h011233, movx_primary_data_pointer_addr);
        apb(8'h86, 1'b1, 32'h20);
        CORE.ev(3'h4, 8'h00);
        rdchk(8'h86, 32'h21);
        settle;
        chk("primary_data_pointer", 24'h02BEEF, movx_primary_data_pointer_addr);
        // guarded register ignores a write without the key
        apb(8'h9D, 1'b1, 32'h02);
        rdchk(8'h9D, 32'h00);
        apb(8'h9B, 1'b1, 32'h12);
        unlock;
        apb(8'h9D, 1'b1, 32'h2A);
        rdchk(8'h9D, 32'h2E);
        settle;
        chk("flat", 1, flat_mode);
        chk("vector", 20'h0B000, vector_base);
        chk("stack", 16'h1210, stack_addr);
        chk("ri", 24'h5C9A34, movx_ri_addr);
        apb(8'hC6, 1'b1, 32'h01);
        rdchk(8'hC6, 32'h00);
        unlock;
        apb(8'hC6, 1'b1, 32'h01);
        rdchk(8'hC6, 32'h01);
        unlock;
        apb(8'hC6, 1'b1, 32'h00);
        rdchk(8'hC6, 32'h00);
        wrap_up;
    end
endmodule
bind addr_ctl addr_ctl_assertions chk_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .push_req,
    .pop_req, .work_value, .pop_data, .pop_valid, .primary_data_pointer_inc, .primary_data_pointer_use,
    .hp_active, .lp_active, .port2_latch, .ri_value, .movx_primary_data_pointer_addr,
    .movx_ri_addr, .stack_addr, .vector_base, .flat_mode,
    .flash_access_cycles);
